// [sensor_power_irq_defs.svh]
// offsets and field positions of the power and interrupt regs, and the oscillator-on reset value
// assumes byte-wide registers on an 8-bit internal address
`ifndef SENSOR_POWER_IRQ_DEFS_SVH
`define SENSOR_POWER_IRQ_DEFS_SVH
`define ADDR_POWER_RESET_CONTROL 8'he0
`define ADDR_INTERRUPT_FLAGS 8'he1
`define ADDR_INTERRUPT_ENABLE 8'he2
`define ADDR_LOCAL_BASE 8'he0
`define BIT_CPU_RESTART 7
`define BIT_FW_UP 6
`define BIT_OSC_ON 0
`define BIT_HISTOGRAM 1
`define BIT_OBJECT 0
`define RST_OSC_ON 1'b1
`define RESTART_PULSE_CYCLES 4'h4
`endif

// [sensor_power_irq_pkg.sv]
// types shared by the power and interrupt register bank
// assumes the defs header is included by users of the numbers
package sensor_power_irq_pkg;
  typedef enum logic [1:0] {
    restart_idle,
    restart_hold
  } restart_state_type;
endpackage

// [restart_pulse.sv]
// stretches a one-cycle restart request into a reset pulse of fixed length
// assumes request comes from logic on the same clock
`timescale 1ns/1ps
`include "sensor_power_irq_defs.svh"
module restart_pulse
  import sensor_power_irq_pkg::*;
#(
  parameter logic [3:0] pulse_cycles = `RESTART_PULSE_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic request,
  output logic active
);
  restart_state_type state_q;
  logic [3:0] count_q;

  // a fresh request while holding restarts the count
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= restart_idle;
      count_q <= 4'h0;
    end else begin
      case (state_q)
        restart_idle: begin
          if (request) begin
            state_q <= restart_hold;
            count_q <= pulse_cycles;
          end
        end
        restart_hold: begin
          if (request) begin
            count_q <= pulse_cycles;
          end else if (count_q <= 4'h1) begin
            state_q <= restart_idle;
            count_q <= 4'h0;
          end else begin
            count_q <= count_q - 4'h1;
          end
        end
        default: begin
          state_q <= restart_idle;
          count_q <= 4'h0;
        end
      endcase
    end
  end

  assign active = (state_q == restart_hold);
endmodule // restart_pulse

// [sensor_power_irq_regs.sv]
// host-visible power, reset and interrupt registers of the distance sensor
// assumes a host-side serial slave delivering byte reads and writes on
// core_clk, and firmware events arriving as same-clock one-cycle pulses
`timescale 1ns/1ps
`include "sensor_power_irq_defs.svh"
module sensor_power_irq_regs
  import sensor_power_irq_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_mapped,
  input wire logic fw_set_up,
  input wire logic fw_clear_up,
  input wire logic fw_standby_done,
  input wire logic measurement_app,
  input wire logic object_result_event,
  input wire logic target_present,
  input wire logic [7:0] persistence,
  input wire logic histogram_event,
  output logic cpu_reset,
  output logic osc_enable,
  output logic oscillator_start_irq,
  output logic boot_reset_req,
  output logic shutdown_irq,
  output logic int_n
);
  logic fw_up_q;
  logic osc_on_q;
  logic osc_run_q;
  logic object_result_flag_q;
  logic histogram_ready_flag_q;
  logic object_result_irq_en_q;
  logic histogram_irq_en_q;
  logic start_irq_q;
  logic boot_reset_q;
  logic shutdown_irq_q;
  logic [7:0] rdata_q;
  logic local_hit;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_enab;
  logic restart_req;
  logic restart_active;
  logic cpu_side_rst;
  logic object_set;

  // addresses below e0 are the firmware's space and vanish while it is down
  assign local_hit = (reg_addr >= `ADDR_LOCAL_BASE);
  assign reg_mapped = local_hit | fw_up_q;
  assign wr_ctrl = reg_wr && (reg_addr == `ADDR_POWER_RESET_CONTROL);
  assign wr_flags = reg_wr && (reg_addr == `ADDR_INTERRUPT_FLAGS);
  assign wr_enab = reg_wr && (reg_addr == `ADDR_INTERRUPT_ENABLE);

  // restart is a write strobe only, never stored, so it reads back zero
  assign restart_req = wr_ctrl && reg_wdata[`BIT_CPU_RESTART];

  restart_pulse u_restart (
    .core_clk(core_clk),
    .srst(srst),
    .request(restart_req),
    .active(restart_active)
  );

  // cpu-side state falls under the cpu restart as well as srst
  assign cpu_side_rst = srst | restart_active;
  assign cpu_reset = restart_active;

  // firmware-up follows firmware and is cleared by the cpu restart; host writes to bit 6 are dropped
  always_ff @(posedge core_clk) begin
    if (cpu_side_rst) begin
      fw_up_q <= 1'b0;
    end else if (fw_set_up) begin
      fw_up_q <= 1'b1;
    end else if (fw_clear_up) begin
      fw_up_q <= 1'b0;
    end
  end

  // oscillator-on bit and the clock request it steers; the host domain
  // is not reset by a cpu restart, so these follow srst only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      osc_on_q <= `RST_OSC_ON;
      osc_run_q <= `RST_OSC_ON;
    end else begin
      if (wr_ctrl) begin
        osc_on_q <= reg_wdata[`BIT_OSC_ON];
      end
      if (wr_ctrl && reg_wdata[`BIT_OSC_ON] && !osc_on_q) begin
        osc_run_q <= 1'b1;
      end else if (fw_standby_done && !osc_on_q) begin
        osc_run_q <= 1'b0;
      end
    end
  end

  // one-cycle interrupts to the embedded processor
  always_ff @(posedge core_clk) begin
    if (srst) begin
      start_irq_q <= 1'b0;
      boot_reset_q <= 1'b0;
      shutdown_irq_q <= 1'b0;
    end else begin
      start_irq_q <= wr_ctrl && reg_wdata[`BIT_OSC_ON] && !osc_on_q;
      // bootloader answers the start by resetting, the app just idles
      boot_reset_q <= wr_ctrl && reg_wdata[`BIT_OSC_ON] && !osc_on_q
                      && !measurement_app;
      shutdown_irq_q <= wr_ctrl && !reg_wdata[`BIT_OSC_ON];
    end
  end
  assign oscillator_start_irq = start_irq_q;
  assign boot_reset_req = boot_reset_q;
  assign shutdown_irq = shutdown_irq_q;
  assign osc_enable = osc_run_q;

  // persistence above zero lets firmware suppress no-target results
  assign object_set = object_result_event &&
                      (target_present || (persistence == 8'h00));

  // sticky flags: a new event in the clearing cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (cpu_side_rst) begin
      object_result_flag_q <= 1'b0;
    end else if (object_set) begin
      object_result_flag_q <= 1'b1;
    end else if (wr_flags && reg_wdata[`BIT_OBJECT]) begin
      object_result_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (cpu_side_rst) begin
      histogram_ready_flag_q <= 1'b0;
    end else if (histogram_event) begin
      histogram_ready_flag_q <= 1'b1;
    end else if (wr_flags && reg_wdata[`BIT_HISTOGRAM]) begin
      histogram_ready_flag_q <= 1'b0;
    end
  end

  // interrupt enables
  always_ff @(posedge core_clk) begin
    if (cpu_side_rst) begin
      object_result_irq_en_q <= 1'b0;
      histogram_irq_en_q <= 1'b0;
    end else if (wr_enab) begin
      object_result_irq_en_q <= reg_wdata[`BIT_OBJECT];
      histogram_irq_en_q <= reg_wdata[`BIT_HISTOGRAM];
    end
  end

  // active-low pin is the nor of enabled flags
  assign int_n = !((object_result_flag_q && object_result_irq_en_q)
                || (histogram_ready_flag_q && histogram_irq_en_q));

  // registered read data, one cycle after reg_rd; others read zero here
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_POWER_RESET_CONTROL: begin
          rdata_q <= {1'b0, fw_up_q, 5'h00, osc_on_q};
        end
        `ADDR_INTERRUPT_FLAGS: begin
          rdata_q <= {6'h00, histogram_ready_flag_q, object_result_flag_q};
        end
        `ADDR_INTERRUPT_ENABLE: begin
          rdata_q <= {6'h00, histogram_irq_en_q, object_result_irq_en_q};
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end
  assign reg_rdata = rdata_q;
endmodule // sensor_power_irq_regs

// [power_irq_properties.sv]
// assertions on the power and interrupt register bank ports
// assumes one clock core_clk and srst as the only reset
`timescale 1ns/1ps
module power_irq_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_mapped,
  input wire logic fw_standby_done,
  input wire logic measurement_app,
  input wire logic object_result_event,
  input wire logic histogram_event,
  input wire logic cpu_reset,
  input wire logic osc_enable,
  input wire logic oscillator_start_irq,
  input wire logic boot_reset_req,
  input wire logic shutdown_irq,
  input wire logic int_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // write to the power control byte
  wire w0 = reg_wr && reg_addr == 8'he0;
  // a fixed pulse so the cpu sees one clean reset, never a stuck level
  restart_len_a: assert property (
    w0 && reg_wdata[7] |=> cpu_reset [*4] ##1 !cpu_reset) else $error("len");
  restart_rd_a: assert property (
    reg_rd && reg_addr == 8'he0 |=> !reg_rdata[7]) else $error("bit7");
  high_map_a: assert property (
    reg_addr >= 8'he0 |-> reg_mapped) else $error("map");
  osc_start_a: assert property (
    w0 && reg_wdata[0] && !osc_enable |=> oscillator_start_irq && osc_enable
    ##1 !oscillator_start_irq) else $error("start");
  boot_req_a: assert property (
    oscillator_start_irq |-> boot_reset_req == !$past(measurement_app))
    else $error("boot");
  // clearing the bit only asks; the oscillator must keep running
  shut_req_a: assert property (
    w0 && !reg_wdata[0] |=> shutdown_irq && osc_enable == $past(osc_enable))
    else $error("shut");
  osc_stop_a: assert property (
    $fell(osc_enable) |-> $past(fw_standby_done)) else $error("stop");
  pin_low_a: assert property (
    $fell(int_n) |-> $past(object_result_event || histogram_event
    || reg_wr && reg_addr == 8'he2)) else $error("pin low");
  pin_high_a: assert property (
    $rose(int_n) |-> $past(reg_wr && reg_addr inside {8'he1, 8'he2})
    || cpu_reset || $past(cpu_reset)) else $error("pin high");
  cover property (oscillator_start_irq);
  cover property (shutdown_irq);
  cover property ($fell(int_n));
endmodule // power_irq_chk
bind sensor_power_irq_regs power_irq_chk chk (.*);

// [host_model.sv]
// host side of the byte register access, one strobe per byte
// assumes the bank samples strobes on the rising core_clk edge
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_mapped,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h5a;
    reg_wdata = 8'ha5;
  end
  // idle edge first so a strobe is never lowered and raised in one step
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic m);
    @(posedge core_clk);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    m = reg_mapped;
    #1;
    q = reg_rdata;
    reg_wr = 0;
    reg_rd = 0;
    // released bus shows the inverse, not a stale copy
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule // host_model

// [sensor_power_irq_regs_tb.sv]
// self-checking bench for the power and interrupt register bank
// assumes host_model drives the bus and the bench the firmware side
`timescale 1ns/1ps
module sensor_power_irq_regs_tb;
  logic core_clk, srst, reg_wr, reg_rd, reg_mapped, m, measurement_app;
  logic fw_set_up, fw_clear_up, fw_standby_done, object_result_event;
  logic histogram_event, target_present, cpu_reset, osc_enable;
  logic oscillator_start_irq, boot_reset_req, shutdown_irq, int_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, persistence, q;
  logic [4:0] ev = 5'h00;
  int bad_count = 0, tests_run = 0, cyc = 0, n;
  // firmware pulses share one vector so a pulse is one assignment
  assign {fw_set_up, fw_clear_up, fw_standby_done, object_result_event,
    histogram_event} = ev;
  sensor_power_irq_regs uut (.*);
  host_model host (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1, a, d, q, m);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(0, a, 8'h00, q, m);
    check(q, e);
  endtask
  // k: 0 histogram, 1 result, 2 standby done, 3 clear up, 4 set up
  task automatic pulse(input int k);
    @(posedge core_clk);
    #1;
    ev = 5'h01 << k;
    @(posedge core_clk);
    #1;
    ev = 5'h00;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  // far above the roughly 80 cycles the sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    srst = 1;
    measurement_app = 1;
    target_present = 1;
    persistence = 8'h00;
    repeat (3) @(posedge core_clk);
    #1;
    srst = 0;
    rd(8'he0, 8'h01);
    rd(8'he1, 8'h00);
    rd(8'he2, 8'h00);
    rd(8'h10, 8'h00);
    check({7'h00, m}, 8'h00);
    pulse(4);
    rd(8'he0, 8'h41);
    // a low address must answer once firmware is up
    rd(8'h10, 8'h00);
    check({7'h00, m}, 8'h01);
    pulse(3);
    wr(8'he0, 8'h41);
    rd(8'he0, 8'h01);
    wr(8'he2, 8'h03);
    rd(8'he2, 8'h03);
    pulse(1);
    check({7'h00, int_n}, 8'h00);
    wr(8'he1, 8'h02);
    rd(8'he1, 8'h01);
    wr(8'he1, 8'h01);
    check({7'h00, int_n}, 8'h01);
    pulse(0);
    rd(8'he1, 8'h02);
    check({7'h00, int_n}, 8'h00);
    wr(8'he2, 8'h01);
    check({7'h00, int_n}, 8'h01);
    wr(8'he1, 8'h02);
    persistence = 8'h01;
    target_present = 0;
    pulse(1);
    rd(8'he1, 8'h00);
    persistence = 8'h00;
    pulse(1);
    rd(8'he1, 8'h01);
    wr(8'he1, 8'h01);
    for (int i = 0; i < 2; i++) begin
      measurement_app = i[0];
      wr(8'he0, 8'h00);
      check({6'h00, shutdown_irq, osc_enable}, 8'h03);
      pulse(2);
      check({7'h00, osc_enable}, 8'h00);
      wr(8'he0, 8'h01);
      check({5'h00, osc_enable, oscillator_start_irq, boot_reset_req},
        {5'h00, 2'b11, !i[0]});
    end
    // firmware up before the restart so the restart has something to clear
    pulse(4);
    wr(8'he2, 8'h03);
    wr(8'he0, 8'h81);
    n = 0;
    repeat (6) begin
      if (cpu_reset === 1'b1)
        n++;
      @(posedge core_clk);
      #1;
    end
    check(8'(n), 8'h04);
    rd(8'he0, 8'h01);
    rd(8'he2, 8'h00);
    test_done;
  end
endmodule // sensor_power_irq_regs_tb
